// *** common/reload_down_timer_two_params.svh ***
// Offsets, field positions, reset values and rates of the reload down timer.
// Included by name; definitions only.
`ifndef RELOAD_DOWN_TIMER_TWO_PARAMS_SVH
`define RELOAD_DOWN_TIMER_TWO_PARAMS_SVH

`define RDT_IDX_CONTROL      6'h19
`define RDT_IDX_RELOAD_HIGH  6'h1a
`define RDT_IDX_RELOAD_LOW   6'h1b
`define RDT_IDX_COUNT_HIGH   6'h1c
`define RDT_IDX_COUNT_LOW    6'h1d
`define RDT_IDX_COMMAND      6'h30
`define RDT_IDX_STATUS       6'h31

`define RDT_CONTROL_RESET    8'h00
`define RDT_RELOAD_RESET     8'h00
`define RDT_CONTROL_WMASK    8'hbb

`define RDT_BIT_CMD_START    0
`define RDT_BIT_CMD_STOP     1
`define RDT_BIT_ST_RUNNING   0
`define RDT_BIT_ST_FLAG      1

`define RDT_SYS_KHZ          18'd250000
`define RDT_FAST_KHZ         18'd13560
`define RDT_SLOW_KHZ         18'd212

`define RDT_RESP_OKAY        2'h0
`define RDT_RESP_DECERR      2'h3

`endif

// *** common/reload_down_timer_two_pkg.sv ***
// Types shared by the reload down timer: control layout, modes and state.
// Assumes the constants header is included by the files that need numbers.
package reload_down_timer_two_pkg;

  typedef enum logic [1:0] {
    START_EXPLICIT  = 2'b00,
    START_TX_END    = 2'b01,
    START_TRIM_NOUF = 2'b10,
    START_TRIM_UF   = 2'b11
  } start_mode_t;

  typedef enum logic [1:0] {
    CLK_FAST   = 2'b00,
    CLK_SLOW   = 2'b01,
    CLK_TIMER0 = 2'b10,
    CLK_TIMER1 = 2'b11
  } clock_select_t;

  typedef struct packed {
    logic          stop_on_receive;
    logic          rsvd6;
    start_mode_t   start_mode;
    logic          auto_restart;
    logic          rsvd2;
    clock_select_t clock_select;
  } ctrl_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } timer_state_t;

endpackage

// *** rtl/reload_down_timer_two.sv ***
// Reload down timer with an AXI4-Lite register slave.
// Assumes all event inputs are synchronous to sys_clk_i and are one-cycle pulses,
// except the trimming oscillator input, which is a level.
`timescale 1ns/1ps
`include "reload_down_timer_two_params.svh"

module reload_down_timer_two #(
  parameter int COUNT_W = 16
) (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        tx_end_i,
  input  wire logic        rx_4bits_i,
  input  wire logic        timer0_underflow_i,
  input  wire logic        timer1_underflow_i,
  input  wire logic        low_freq_oscillator_i,
  output logic             underflow_o,
  output logic             underflow_flag_o,
  output logic             running_o
);

  // The count is shown to software as two bytes, so only a 16-bit counter is served.
  if (COUNT_W != 16) begin : g_bad_count_w
    $error("COUNT_W must be 16: the count is shown as two bytes.");
  end

  reload_down_timer_two_pkg::ctrl_t        ctrl;
  reload_down_timer_two_pkg::timer_state_t state;
  logic [7:0]         reload_high;
  logic [7:0]         reload_low;
  logic [COUNT_W-1:0] count;
  logic [17:0]        acc_fast;
  logic [17:0]        acc_slow;
  logic               lfo_prev;
  logic [7:0]         aw_addr;
  logic               aw_held;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic               w_held;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Fractional dividers: add the tick rate each cycle, wrap at the system rate.
  // The average rate is exact; single ticks jitter by one system cycle.
  // The sums carry one extra bit: accumulator plus fast rate can pass the 18-bit range.
  wire [18:0] fast_sum  = acc_fast + `RDT_FAST_KHZ;
  wire [18:0] slow_sum  = acc_slow + `RDT_SLOW_KHZ;
  wire        fast_wrap = fast_sum >= `RDT_SYS_KHZ;
  wire        slow_wrap = slow_sum >= `RDT_SYS_KHZ;
  wire [18:0] fast_left = fast_wrap ? fast_sum - `RDT_SYS_KHZ : fast_sum;
  wire [18:0] slow_left = slow_wrap ? slow_sum - `RDT_SYS_KHZ : slow_sum;
  wire [17:0] next_acc_fast = fast_left[17:0];
  wire [17:0] next_acc_slow = slow_left[17:0];

  wire tick = (ctrl.clock_select == reload_down_timer_two_pkg::CLK_FAST)   ? fast_wrap :
              (ctrl.clock_select == reload_down_timer_two_pkg::CLK_SLOW)   ? slow_wrap :
              (ctrl.clock_select == reload_down_timer_two_pkg::CLK_TIMER0) ? timer0_underflow_i :
              timer1_underflow_i;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_fast <= 18'h00000;
      acc_slow <= 18'h00000;
      lfo_prev <= 1'b0;
    end else begin
      acc_fast <= next_acc_fast;
      acc_slow <= next_acc_slow;
      lfo_prev <= low_freq_oscillator_i;
    end
  end

  // Register slave: address and data are held independently, the write fires once both are in.
  wire aw_fire = s_axi_awvalid_i & s_axi_awready_o;
  wire w_fire  = s_axi_wvalid_i & s_axi_wready_o;
  wire wr_go   = aw_held & w_held & ~s_axi_bvalid_o;
  wire ar_fire = s_axi_arvalid_i & s_axi_arready_o;

  wire       wr_word_ok = (aw_addr[1:0] == 2'b00);
  wire       wr_lane0   = wr_go & wr_word_ok & w_strb[0];
  wire       wr_ctrl    = wr_lane0 & (aw_addr[7:2] == `RDT_IDX_CONTROL);
  wire       wr_rhigh   = wr_lane0 & (aw_addr[7:2] == `RDT_IDX_RELOAD_HIGH);
  wire       wr_rlow    = wr_lane0 & (aw_addr[7:2] == `RDT_IDX_RELOAD_LOW);
  wire       wr_cmd     = wr_lane0 & (aw_addr[7:2] == `RDT_IDX_COMMAND);
  wire       wr_status  = wr_lane0 & (aw_addr[7:2] == `RDT_IDX_STATUS);
  wire       wr_mapped  = wr_word_ok & ((aw_addr[7:2] >= `RDT_IDX_CONTROL && aw_addr[7:2] <= `RDT_IDX_COUNT_LOW) ||
                                        aw_addr[7:2] == `RDT_IDX_COMMAND || aw_addr[7:2] == `RDT_IDX_STATUS);
  wire       cmd_start  = wr_cmd & w_data[`RDT_BIT_CMD_START];
  wire       cmd_stop   = wr_cmd & w_data[`RDT_BIT_CMD_STOP];
  wire       flag_clear = wr_status & w_data[`RDT_BIT_ST_FLAG];

  // Timer control decode.
  wire running   = (state == reload_down_timer_two_pkg::ST_RUN);
  wire trim_mode = ctrl.start_mode[1];
  wire lfo_rise  = low_freq_oscillator_i & ~lfo_prev;
  wire at_zero   = (count == 16'h0000);
  wire [COUNT_W-1:0] reload_value = {reload_high, reload_low};

  // start events by mode; mode 00b only takes the command.
  wire start_evt = cmd_start |
                   ((ctrl.start_mode == reload_down_timer_two_pkg::START_TX_END) & tx_end_i) |
                   (trim_mode & lfo_rise & ~running);
  // stop on receive, masked in trimming modes.
  wire rx_stop   = ctrl.stop_on_receive & ~trim_mode & rx_4bits_i;
  wire stop_evt  = cmd_stop | rx_stop | (trim_mode & lfo_rise & running);
  wire step      = running & tick & ~start_evt & ~stop_evt;
  // underflow is a tick at zero, suppressed when trimming without underflow.
  wire uf_evt    = step & at_zero & (ctrl.start_mode != reload_down_timer_two_pkg::START_TRIM_NOUF);

  reload_down_timer_two_pkg::timer_state_t next_state;
  logic [COUNT_W-1:0]                      next_count;
  always_comb begin
    next_state = state;
    next_count = count;
    if (start_evt) begin
      next_state = reload_down_timer_two_pkg::ST_RUN;
      next_count = reload_value;
    end else if (stop_evt) begin
      next_state = reload_down_timer_two_pkg::ST_IDLE;
    end else if (uf_evt) begin
      // restart from the reload value or stop at zero.
      if (ctrl.auto_restart) begin
        next_count = reload_value;
      end else begin
        next_state = reload_down_timer_two_pkg::ST_IDLE;
      end
    end else if (step && !at_zero) begin
      next_count = count - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= reload_down_timer_two_pkg::ST_IDLE;
      count <= 16'h0000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // The flag set wins over a software clear in the same cycle.
  // underflow sets the sticky flag.
  wire next_flag = uf_evt | (underflow_flag_o & ~flag_clear);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      underflow_o      <= 1'b0;
      underflow_flag_o <= 1'b0;
      running_o        <= 1'b0;
    end else begin
      underflow_o      <= uf_evt;
      underflow_flag_o <= next_flag;
      running_o        <= (next_state == reload_down_timer_two_pkg::ST_RUN);
    end
  end

  // reload bytes are stored apart from the counter and only read at a start or an auto restart.
  wire [7:0] next_ctrl = (w_data[7:0] & `RDT_CONTROL_WMASK);
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl        <= `RDT_CONTROL_RESET;
      reload_high <= `RDT_RELOAD_RESET;
      reload_low  <= `RDT_RELOAD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (wr_rhigh) begin
        reload_high <= w_data[7:0];
      end
      if (wr_rlow) begin
        reload_low <= w_data[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= 32'h00000000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `RDT_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held         <= 1'b1;
        aw_addr         <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (w_fire) begin
        w_held         <= 1'b1;
        w_data         <= s_axi_wdata_i;
        w_strb         <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_mapped ? `RDT_RESP_OKAY : `RDT_RESP_DECERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Read path; count bytes are sampled live, so a two-byte read is not atomic.
  wire [5:0] rd_idx = s_axi_araddr_i[7:2];
  wire       rd_ok  = (s_axi_araddr_i[1:0] == 2'b00);
  wire [7:0] rd_byte = (rd_idx == `RDT_IDX_CONTROL)     ? ctrl :
                       (rd_idx == `RDT_IDX_RELOAD_HIGH) ? reload_high :
                       (rd_idx == `RDT_IDX_RELOAD_LOW)  ? reload_low :
                       (rd_idx == `RDT_IDX_COUNT_HIGH)  ? count[15:8] :
                       (rd_idx == `RDT_IDX_COUNT_LOW)   ? count[7:0] :
                       (rd_idx == `RDT_IDX_STATUS)      ? {6'h00, underflow_flag_o, running} :
                       8'h00;
  wire       rd_mapped = rd_ok & ((rd_idx >= `RDT_IDX_CONTROL && rd_idx <= `RDT_IDX_COUNT_LOW) ||
                                  rd_idx == `RDT_IDX_COMMAND || rd_idx == `RDT_IDX_STATUS);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= `RDT_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_mapped ? {24'h000000, rd_byte} : 32'h00000000;
        s_axi_rresp_o   <= rd_mapped ? `RDT_RESP_OKAY : `RDT_RESP_DECERR;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  sequence s_rx_stop_req;
    running && rx_stop && !start_evt;
  endsequence

  sequence s_underflow;
    uf_evt;
  endsequence

  a_rx_stop_halts: assert property (s_rx_stop_req |=> !running_o)
    else $error("Timer kept running after four received bits.");

  a_trim_ignores_rx: assert property (
    running && trim_mode && rx_4bits_i && !cmd_stop && !lfo_rise && !uf_evt |=> running_o)
    else $error("Receive stop acted in a trimming mode.");

  a_no_auto_start: assert property (
    !running && ctrl.start_mode == reload_down_timer_two_pkg::START_EXPLICIT && !cmd_start |=> !running_o)
    else $error("Timer started without a command in explicit mode.");

  a_tx_end_loads: assert property (
    ctrl.start_mode == reload_down_timer_two_pkg::START_TX_END && tx_end_i
    |=> running_o && count == $past(reload_value))
    else $error("End of transmission did not start the timer.");

  a_trim_holds_zero: assert property (
    ctrl.start_mode == reload_down_timer_two_pkg::START_TRIM_NOUF && step && at_zero
    |=> count == 16'h0000 && running_o && !underflow_o)
    else $error("Trimming without underflow let the count underflow.");

  a_trim_edge_toggles: assert property (
    trim_mode && lfo_rise && !cmd_start && !cmd_stop |=> running_o == !$past(running))
    else $error("Oscillator edge did not toggle the trimming run.");

  a_restart_reload: assert property (s_underflow ##0 ctrl.auto_restart
    |=> running_o && count == $past(reload_value))
    else $error("Auto restart did not reload the counter.");

  a_stop_at_zero: assert property (s_underflow ##0 !ctrl.auto_restart
    |=> !running_o ##1 (!running || start_evt))
    else $error("Timer without auto restart kept running after underflow.");

  a_flag_on_underflow: assert property (s_underflow |=> underflow_flag_o && underflow_o)
    else $error("Underflow did not set the flag.");

  a_cascade_tick: assert property (
    ctrl.clock_select == reload_down_timer_two_pkg::CLK_TIMER0 && running && timer0_underflow_i &&
    !start_evt && !stop_evt && !at_zero |=> count == $past(count) - 16'h0001)
    else $error("First timer underflow did not decrement the count.");

  a_fast_rate: assert property (
    ctrl.clock_select == reload_down_timer_two_pkg::CLK_FAST && running && !at_zero && !start_evt && !stop_evt
    ##1 ($stable(ctrl) && !start_evt && !stop_evt && count > 16'h0020) [*8]
    |-> count <= $past(count, 8) && count >= $past(count, 8) - 16'h0001)
    else $error("Fast clock selection stepped the count at the wrong rate.");

  a_reload_no_disturb: assert property (
    (wr_rhigh || wr_rlow) && running && !start_evt && !tick && !stop_evt |=> count == $past(count))
    else $error("Reload write disturbed a running count.");

  a_start_loads: assert property (start_evt |=> running_o && count == $past(reload_value))
    else $error("Start event did not load the reload value.");

  a_step_decrements: assert property (step && !at_zero |=> count == $past(count) - 16'h0001)
    else $error("Tick did not decrement the count by one.");

  a_count_low_read: assert property (ar_fire && rd_ok && rd_idx == `RDT_IDX_COUNT_LOW
    |=> s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(count[7:0]))
    else $error("Count low byte read did not show the live count.");

  a_flag_set_wins: assert property (uf_evt && flag_clear |=> underflow_flag_o)
    else $error("Software clear beat an underflow in the same cycle.");

endmodule

// *** verification/test_reload_down_timer_two.sv ***
// Self-checking bench for the reload down timer: register table, counting, starts and stops.
// Assumes the design's AXI4-Lite slave and the event inputs are synchronous to sys_clk_i.
`timescale 1ns/1ps
`include "reload_down_timer_two_params.svh"
module test_reload_down_timer_two;
  localparam logic [7:0] A_CTRL = {`RDT_IDX_CONTROL, 2'b00};
  localparam logic [7:0] A_RHI  = {`RDT_IDX_RELOAD_HIGH, 2'b00};
  localparam logic [7:0] A_RLO  = {`RDT_IDX_RELOAD_LOW, 2'b00};
  localparam logic [7:0] A_CHI  = {`RDT_IDX_COUNT_HIGH, 2'b00};
  localparam logic [7:0] A_CLO  = {`RDT_IDX_COUNT_LOW, 2'b00};
  localparam logic [7:0] A_CMD  = {`RDT_IDX_COMMAND, 2'b00};
  localparam logic [7:0] A_STAT = {`RDT_IDX_STATUS, 2'b00};
  localparam int TX = 0, RX = 1, T0 = 2, T1 = 3;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [1:0] r;
  } row_t;
  row_t rows [6] = '{'{A_CTRL, 8'hff, 8'hbb, 2'h0}, '{A_RHI, 8'h12, 8'h12, 2'h0},
                     '{A_RLO, 8'h34, 8'h34, 2'h0}, '{A_CHI, 8'h55, 8'h00, 2'h0},
                     '{A_CLO, 8'h55, 8'h00, 2'h0}, '{8'h80, 8'h77, 8'h00, 2'h3}};
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [3:0]  ev      = 4'h0;
  logic        osc     = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, uf_pulse, flag, running;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [15:0] cnt;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          uf_cnt = 0;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (uf_pulse) uf_cnt <= uf_cnt + 1;

  reload_down_timer_two DUT (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .tx_end_i(ev[TX]), .rx_4bits_i(ev[RX]), .timer0_underflow_i(ev[T0]), .timer1_underflow_i(ev[T1]),
    .low_freq_oscillator_i(osc), .underflow_o(uf_pulse), .underflow_flag_o(flag), .running_o(running));

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Each channel is released at the edge that takes it; a wait that runs out ends the run.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit aw, w, b, got;
    int n;
    @(posedge sys_clk);
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 64 && !got; n++) begin
      #1 aw = awvalid && awready; w = wvalid && wready; b = bvalid; resp = bresp;
      @(posedge sys_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin bready <= 1'b0; got = 1'b1; end
    end
    if (!got) begin chk(32'h0, 32'h1); close_out(); end
  endtask

  task automatic rdr(input logic [7:0] a);
    bit ar, r, got;
    int n;
    @(posedge sys_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 64 && !got; n++) begin
      #1 ar = arvalid && arready; r = rvalid; rd = rdata; resp = rresp;
      @(posedge sys_clk);
      if (ar) arvalid <= 1'b0;
      if (r) begin rready <= 1'b0; got = 1'b1; end
    end
    if (!got) begin chk(32'h0, 32'h1); close_out(); end
  endtask

  // No reception reads.
  // The two count bytes are not read atomically, so they are read only while no tick can land.
  task automatic rd_count;
    logic [7:0] h;
    rdr(A_CHI); h = rd[7:0];
    rdr(A_CLO); cnt = {h, rd[7:0]};
  endtask

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge sys_clk); ev[k] <= 1'b1;
      @(posedge sys_clk); ev[k] <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask

  task automatic osc_edge;
    @(posedge sys_clk); osc <= 1'b1;
    repeat (3) @(posedge sys_clk); osc <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic run_for(input logic [7:0] ctl, input int cycles, input int lo, input int hi);
    wr(A_CTRL, ctl); wr(A_RHI, 8'hff); wr(A_RLO, 8'hff); wr(A_CMD, 8'h01);
    repeat (cycles) @(posedge sys_clk);
    wr(A_CMD, 8'h02); rd_count();
    chk(32'((16'hffff - cnt) >= lo && (16'hffff - cnt) <= hi), 32'h1);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].d); chk(32'(resp), 32'(rows[i].r));
      rdr(rows[i].a); chk(rd, 32'(rows[i].q));
      chk(32'(resp), 32'(rows[i].r));
    end
    $display("test register table done");
    @(posedge sys_clk); arst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    rdr(A_CTRL); chk(rd, 32'h0);
    rdr(A_RHI); chk(rd, 32'h0);
    rdr(A_RLO); chk(rd, 32'h0);
    rd_count(); chk(32'(cnt), 32'h0);
    #1 chk(32'(running), 32'h0);
    $display("test mid-run reset done");
    wr(A_CTRL, 8'h02); wr(A_RLO, 8'h03);
    pulse(TX, 1); #1 chk(32'(running), 32'h0);
    wr(A_CMD, 8'h01); wr(A_RLO, 8'h09);
    rd_count(); chk(32'(cnt), 32'h3);
    pulse(T0, 3); rd_count(); chk(32'(cnt), 32'h0);
    #1 chk(32'(running), 32'h1);
    pulse(T0, 1); #1 chk(32'(running), 32'h0);
    chk(32'(flag), 32'h1);
    chk(32'(uf_cnt), 32'h1);
    wr(A_STAT, 8'h02); #1 chk(32'(flag), 32'h0);
    wr(A_CMD, 8'h01); rd_count(); chk(32'(cnt), 32'h9);
    wr(A_CMD, 8'h02); #1 chk(32'(running), 32'h0);
    $display("test explicit start done");
    wr(A_CTRL, 8'h0a); wr(A_RLO, 8'h02); wr(A_CMD, 8'h01);
    pulse(T0, 3); #1 chk(32'(running), 32'h1);
    chk(32'(uf_cnt), 32'h2);
    rd_count(); chk(32'(cnt), 32'h2);
    wr(A_CMD, 8'h02);
    $display("test auto restart done");
    wr(A_CTRL, 8'h12); pulse(TX, 1); #1 chk(32'(running), 32'h1);
    pulse(RX, 1); #1 chk(32'(running), 32'h1);
    wr(A_CMD, 8'h02); wr(A_CTRL, 8'h92);
    pulse(TX, 1); #1 chk(32'(running), 32'h1);
    pulse(RX, 1); #1 chk(32'(running), 32'h0);
    $display("test transceiver events done");
    wr(A_STAT, 8'h02); wr(A_CTRL, 8'ha2); wr(A_RLO, 8'h01);
    osc_edge(); #1 chk(32'(running), 32'h1);
    pulse(RX, 1); pulse(T0, 2); #1 chk(32'(running), 32'h1);
    chk(32'(flag), 32'h0);
    osc_edge(); #1 chk(32'(running), 32'h0);
    wr(A_CTRL, 8'hb2); osc_edge(); pulse(T0, 2);
    #1 chk(32'(flag), 32'h1);
    chk(32'(uf_cnt), 32'h3);
    $display("test trimming modes done");
    wr(A_CTRL, 8'h03); wr(A_RLO, 8'h05); wr(A_CMD, 8'h01);
    pulse(T0, 1); rd_count(); chk(32'(cnt), 32'h5);
    pulse(T1, 1); rd_count(); chk(32'(cnt), 32'h4);
    wr(A_CMD, 8'h02);
    run_for(8'h00, 1000, 52, 57);
    run_for(8'h01, 4720, 3, 5);
    $display("test clock selection done");
    close_out();
  end
endmodule
